// [design/aisi_pkg.sv]
// Constants for the analog input status image: register map, field layout,
// reset values and timing figures. Shared by the top and its two helpers.
package aisi_pkg;

   localparam int NCH       = 4;
   localparam int DW        = 16;
   localparam int AW        = 5;
   localparam int STAMP_W   = 15;
   localparam int REL_W     = 8;

   // Input image words, at their printed word offsets
   localparam logic [4:0] ADDR_VALUE_BASE = 5'h00;
   localparam logic [4:0] ADDR_STAMP      = 5'h04;
   localparam logic [4:0] ADDR_ERR        = 5'h05;
   localparam logic [4:0] ADDR_FLAGS      = 5'h06;
   // Output image word 0 shares offset 0 for writes; it reads back at offset 5'h10
   localparam logic [4:0] ADDR_RELEASE    = 5'h00;
   localparam logic [4:0] ADDR_RELEASE_RB = 5'h10;
   localparam logic [4:0] ADDR_CFG1       = 5'h11;
   localparam logic [4:0] ADDR_CH_EN      = 5'h12;
   localparam logic [4:0] ADDR_ALM_EN     = 5'h13;
   localparam logic [4:0] ADDR_LATCH_EN   = 5'h14;
   localparam logic [4:0] ADDR_HI_BASE    = 5'h18;
   localparam logic [4:0] ADDR_LO_BASE    = 5'h1C;

   localparam int STAMP_EN_POS = 15;
   localparam int SIGN_POS     = 15;
   localparam int FLG_STRIDE   = 4;
   localparam int FLG_ABOVE    = 0;
   localparam int FLG_BELOW    = 1;
   localparam int FLG_HIGH     = 2;
   localparam int FLG_LOW      = 3;
   localparam int REL_STRIDE   = 2;
   localparam int REL_HIGH     = 0;
   localparam int REL_LOW      = 1;

   localparam logic [15:0] WORD_ZERO    = 16'h0000;
   localparam logic [15:0] FULL_MAX_DEF = 16'h7FFF;
   localparam logic [15:0] FULL_MIN_DEF = 16'h8000;
   localparam logic [15:0] NORM_MAX_DEF = 16'h7C00;
   localparam logic [15:0] NORM_MIN_DEF = 16'h8400;

   localparam int unsigned MS_NS     = 1000000;
   localparam int unsigned CLK_NS    = 25;
   localparam int unsigned MS_CYCLES = MS_NS / CLK_NS;

endpackage

// [design/aisi_stamp.sv]
// Rolling millisecond counter and the timestamp word captured per update.
// Assumes one clock and a one-cycle update strobe from the converter side.
`timescale 1ns/1ps
`default_nettype none
module aisi_stamp #(
   parameter int unsigned MS_CYCLES = aisi_pkg::MS_CYCLES
) (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        smp_valid_in,
   input  wire logic        stamp_en_in,
   output logic [15:0]      stamp_out
);
   import aisi_pkg::*;

   localparam int TW = $clog2(MS_CYCLES);
   localparam logic [TW-1:0] TICK_LAST = TW'(MS_CYCLES - 1);

   logic [TW-1:0]      tick_r;
   logic [STAMP_W-1:0] ms_r;
   wire                tick_w = (tick_r == TICK_LAST);

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tick_r <= '0;
         ms_r   <= '0;
      end else begin
         tick_r <= tick_w ? '0 : tick_r + 1'b1;
         if (tick_w) begin
            ms_r <= ms_r + 1'b1;
         end
      end
   end

   // Top bit is spare and always zero
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         stamp_out <= WORD_ZERO;
      end else if (smp_valid_in) begin
         stamp_out <= stamp_en_in ? {1'b0, ms_r} : WORD_ZERO;
      end
   end

   stamp_cap_a: assert property (@(posedge clk_in) disable iff (rst_in)
      smp_valid_in && stamp_en_in |=> stamp_out == {1'b0, $past(ms_r)})
      else $error("timestamp not captured on update");
   stamp_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
      smp_valid_in && !stamp_en_in |=> stamp_out == WORD_ZERO)
      else $error("timestamp written while disabled");
endmodule
`default_nettype wire

// [design/aisi_chan.sv]
// One input channel: range and limit compare, clamped conversion word.
// Assumes the sample and open-wire inputs come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module aisi_chan #(
   parameter logic [15:0] FULL_MAX = aisi_pkg::FULL_MAX_DEF,
   parameter logic [15:0] FULL_MIN = aisi_pkg::FULL_MIN_DEF,
   parameter logic [15:0] NORM_MAX = aisi_pkg::NORM_MAX_DEF,
   parameter logic [15:0] NORM_MIN = aisi_pkg::NORM_MIN_DEF
) (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        smp_valid_in,
   input  wire logic [15:0] smp_data_in,
   input  wire logic        open_wire_in,
   input  wire logic        chan_en_in,
   input  wire logic        alarm_en_in,
   input  wire logic [15:0] high_thr_in,
   input  wire logic [15:0] low_thr_in,
   output logic [15:0]      data_out,
   output logic             above_out,
   output logic             below_out,
   output logic             high_out,
   output logic             low_out,
   output logic             high_rise_out,
   output logic             low_rise_out
);
   import aisi_pkg::*;

   wire signed [15:0] raw_w   = smp_data_in;
   wire               above_w = raw_w > $signed(NORM_MAX);
   wire               below_w = (raw_w < $signed(NORM_MIN)) | open_wire_in;
   wire               high_w  = alarm_en_in & (raw_w > $signed(high_thr_in));
   wire               low_w   = alarm_en_in & (raw_w < $signed(low_thr_in));
   // Out-of-range input pins the word to the full-range end
   // Open wire wins over any high reading: a broken loop must pin low
   wire [15:0]        data_w  = (~open_wire_in & (high_w | above_w)) ? FULL_MAX :
                                (low_w | below_w) ? FULL_MIN :
                                smp_data_in;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         data_out      <= WORD_ZERO;
         above_out     <= 1'b0;
         below_out     <= 1'b0;
         high_out      <= 1'b0;
         low_out       <= 1'b0;
         high_rise_out <= 1'b0;
         low_rise_out  <= 1'b0;
      end else begin
         high_rise_out <= 1'b0;
         low_rise_out  <= 1'b0;
         if (smp_valid_in) begin
            // Disabled channel shows zeros from its next update on; until then data_out holds its last word
            data_out      <= chan_en_in ? data_w : WORD_ZERO;
            above_out     <= chan_en_in & above_w;
            below_out     <= chan_en_in & below_w;
            high_out      <= chan_en_in & high_w;
            low_out       <= chan_en_in & low_w;
            high_rise_out <= chan_en_in & high_w & ~high_out;
            low_rise_out  <= chan_en_in & low_w & ~low_out;
         end
      end
   end
endmodule
`default_nettype wire

// [design/aisi_top.sv]
// Register image of a four-channel analog input: conversion words,
// timestamp, error summary, range and limit flags, latch release controls.
// Assumes the converter hands one update strobe with all four samples.
//
// Notes on behaviour
// - Words 0 to 3 carry channels 0 to 3, valid when enabled, error free.
// - Conversion words are signed two's complement, bit 15 is sign.
// - Unused input image bits always read zero.
// - Word 5 bits 0 to 3 hold one error flag per channel.
// - Error flag is the OR of above, below, high and low flags.
// - Low flags at word 6 bits 3,7,11,15; data pinned to full minimum.
// - High flags at word 6 bits 2,6,10,14; data pinned to full maximum unless open wire.
// - Unlatched alarm flags clear once the condition goes away.
// - Latched alarm flags stay until the matching release bit clears them.
// - Above-range flags at bits 0,4,8,12; data pinned to full maximum unless open wire.
// - Below-range flags at bits 1,5,9,13, open wire included; data minimum.
// - Range flags clear themselves when data is back in normal range.
// - When enabled, 15-bit 1 ms rolling stamp written to word 4 per update.
// - Stamp enabled or disabled by bit 15 of configuration word 1.
// - Output word 0 bits 0 to 7 hold high and low release bits.
// - Latch released only while release bit is one and condition absent.
// - Alarm rising while release bit is one is not latched.
// - High and low flags clear at once when a channel is disabled; range flags at its next update.
`timescale 1ns/1ps
`default_nettype none
module aisi_top #(
   parameter int unsigned MS_CYCLES = aisi_pkg::MS_CYCLES
) (
   input  wire logic                        REF_CLK_IN,
   input  wire logic                        RST_IN,
   input  wire logic [aisi_pkg::AW-1:0]     ADDR_IN,
   input  wire logic [aisi_pkg::DW-1:0]     WDATA_IN,
   input  wire logic                        WR_IN,
   input  wire logic                        RD_IN,
   output logic      [aisi_pkg::DW-1:0]     RDATA_OUT,
   input  wire logic                        SAMPLE_VALID_IN,
   input  wire logic [4*aisi_pkg::DW-1:0]   SAMPLE_DATA_IN,
   input  wire logic [aisi_pkg::NCH-1:0]    OPEN_WIRE_IN
);
   import aisi_pkg::*;

   // Configuration and control registers
   logic [REL_W-1:0]   release_r;
   logic               stamp_en_r;
   logic [NCH-1:0]     ch_en_r;
   logic [NCH-1:0]     alm_en_r;
   logic [NCH-1:0]     lat_en_r;
   logic [DW-1:0]      hi_thr_r [NCH];
   logic [DW-1:0]      lo_thr_r [NCH];
   logic [DW-1:0]      rdata_r;

   // Per-channel state
   logic [DW-1:0]      value_w  [NCH];
   logic [NCH-1:0]     above_w;
   logic [NCH-1:0]     below_w;
   logic [NCH-1:0]     hi_cond_w;
   logic [NCH-1:0]     lo_cond_w;
   logic [NCH-1:0]     hi_rise_w;
   logic [NCH-1:0]     lo_rise_w;
   logic [NCH-1:0]     hi_lat_r;
   logic [NCH-1:0]     lo_lat_r;
   logic [NCH-1:0]     hi_lat_nxt;
   logic [NCH-1:0]     lo_lat_nxt;
   logic [NCH-1:0]     hi_flag_w;
   logic [NCH-1:0]     lo_flag_w;
   logic [NCH-1:0]     err_w;
   logic [NCH-1:0]     rel_hi_w;
   logic [NCH-1:0]     rel_lo_w;
   logic [DW-1:0]      flags_w;
   logic [DW-1:0]      stamp_w;

   // Address decode
   wire [1:0] idx_w      = ADDR_IN[1:0];
   wire       wr_rel_w   = WR_IN && (ADDR_IN == ADDR_RELEASE);
   wire       wr_cfg1_w  = WR_IN && (ADDR_IN == ADDR_CFG1);
   wire       wr_chen_w  = WR_IN && (ADDR_IN == ADDR_CH_EN);
   wire       wr_alm_w   = WR_IN && (ADDR_IN == ADDR_ALM_EN);
   wire       wr_lat_w   = WR_IN && (ADDR_IN == ADDR_LATCH_EN);
   wire       wr_hi_w    = WR_IN && (ADDR_IN[4:2] == ADDR_HI_BASE[4:2]);
   wire       wr_lo_w    = WR_IN && (ADDR_IN[4:2] == ADDR_LO_BASE[4:2]);
   wire       rd_value_w = ADDR_IN[4:2] == ADDR_VALUE_BASE[4:2];
   wire       rd_hi_w    = ADDR_IN[4:2] == ADDR_HI_BASE[4:2];
   wire       rd_lo_w    = ADDR_IN[4:2] == ADDR_LO_BASE[4:2];

   // Controller keeps bits 8..15 zero; they are not stored anyway
   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         release_r <= '0;
      end else if (wr_rel_w) begin
         release_r <= WDATA_IN[REL_W-1:0];
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         stamp_en_r <= 1'b0;
         ch_en_r    <= '0;
         alm_en_r   <= '0;
         lat_en_r   <= '0;
      end else begin
         if (wr_cfg1_w) begin
            stamp_en_r <= WDATA_IN[STAMP_EN_POS];
         end
         if (wr_chen_w) begin
            ch_en_r <= WDATA_IN[NCH-1:0];
         end
         if (wr_alm_w) begin
            alm_en_r <= WDATA_IN[NCH-1:0];
         end
         if (wr_lat_w) begin
            lat_en_r <= WDATA_IN[NCH-1:0];
         end
      end
   end

   aisi_stamp #(
      .MS_CYCLES (MS_CYCLES)
   ) u_stamp (
      .clk_in       (REF_CLK_IN),
      .rst_in       (RST_IN),
      .smp_valid_in (SAMPLE_VALID_IN),
      .stamp_en_in  (stamp_en_r),
      .stamp_out    (stamp_w)
   );

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         always_ff @(posedge REF_CLK_IN) begin
            if (RST_IN) begin
               hi_thr_r[g] <= WORD_ZERO;
               lo_thr_r[g] <= WORD_ZERO;
            end else begin
               if (wr_hi_w && idx_w == 2'(g)) begin
                  hi_thr_r[g] <= WDATA_IN;
               end
               if (wr_lo_w && idx_w == 2'(g)) begin
                  lo_thr_r[g] <= WDATA_IN;
               end
            end
         end

         aisi_chan u_chan (
            .clk_in        (REF_CLK_IN),
            .rst_in        (RST_IN),
            .smp_valid_in  (SAMPLE_VALID_IN),
            .smp_data_in   (SAMPLE_DATA_IN[g*DW +: DW]),
            .open_wire_in  (OPEN_WIRE_IN[g]),
            .chan_en_in    (ch_en_r[g]),
            .alarm_en_in   (alm_en_r[g]),
            .high_thr_in   (hi_thr_r[g]),
            .low_thr_in    (lo_thr_r[g]),
            .data_out      (value_w[g]),
            .above_out     (above_w[g]),
            .below_out     (below_w[g]),
            .high_out      (hi_cond_w[g]),
            .low_out       (lo_cond_w[g]),
            .high_rise_out (hi_rise_w[g]),
            .low_rise_out  (lo_rise_w[g])
         );

         assign rel_hi_w[g] = release_r[g*REL_STRIDE+REL_HIGH];
         assign rel_lo_w[g] = release_r[g*REL_STRIDE+REL_LOW];

         // A rise seen while release is held does not latch
         assign hi_lat_nxt[g] = lat_en_r[g] & ch_en_r[g] &
                                ((hi_rise_w[g] & ~rel_hi_w[g]) |
                                 (hi_lat_r[g] & ~(rel_hi_w[g] & ~hi_cond_w[g])));
         assign lo_lat_nxt[g] = lat_en_r[g] & ch_en_r[g] &
                                ((lo_rise_w[g] & ~rel_lo_w[g]) |
                                 (lo_lat_r[g] & ~(rel_lo_w[g] & ~lo_cond_w[g])));

         always_ff @(posedge REF_CLK_IN) begin
            if (RST_IN) begin
               hi_lat_r[g] <= 1'b0;
               lo_lat_r[g] <= 1'b0;
            end else begin
               hi_lat_r[g] <= hi_lat_nxt[g];
               lo_lat_r[g] <= lo_lat_nxt[g];
            end
         end

         // Unlatched flags simply follow the live condition
         assign hi_flag_w[g] = ch_en_r[g] & (hi_cond_w[g] | hi_lat_r[g]);
         assign lo_flag_w[g] = ch_en_r[g] & (lo_cond_w[g] | lo_lat_r[g]);
         assign err_w[g]     = above_w[g] | below_w[g] |
                               hi_flag_w[g] | lo_flag_w[g];

         assign flags_w[g*FLG_STRIDE+FLG_ABOVE] = above_w[g];
         assign flags_w[g*FLG_STRIDE+FLG_BELOW] = below_w[g];
         assign flags_w[g*FLG_STRIDE+FLG_HIGH]  = hi_flag_w[g];
         assign flags_w[g*FLG_STRIDE+FLG_LOW]   = lo_flag_w[g];

         over_clamp_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
            SAMPLE_VALID_IN && ch_en_r[g] && !OPEN_WIRE_IN[g] &&
            $signed(SAMPLE_DATA_IN[g*DW +: DW]) > $signed(NORM_MAX_DEF)
            |=> above_w[g] && value_w[g] == FULL_MAX_DEF)
            else $error("above range not flagged or not pinned");

         open_wire_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
            SAMPLE_VALID_IN && ch_en_r[g] && OPEN_WIRE_IN[g]
            |=> below_w[g] && value_w[g] == FULL_MIN_DEF)
            else $error("open wire not reported as below range");

         latch_hold_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
            hi_lat_r[g] && lat_en_r[g] && ch_en_r[g] && !rel_hi_w[g]
            |=> hi_lat_r[g])
            else $error("latched high alarm dropped without release");

         release_wait_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
            lo_lat_r[g] && rel_lo_w[g] && lo_cond_w[g] && lat_en_r[g] && ch_en_r[g]
            |=> lo_lat_r[g])
            else $error("low latch released while condition persists");

         release_done_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
            hi_lat_r[g] && rel_hi_w[g] && !hi_cond_w[g] && !hi_rise_w[g]
            |=> !hi_lat_r[g])
            else $error("high latch not released");

         no_latch_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
            hi_rise_w[g] && rel_hi_w[g] && !hi_lat_r[g] |=> !hi_lat_r[g])
            else $error("alarm latched while release bit set");

         unlatched_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
            !lat_en_r[g] ##1 !hi_cond_w[g] |-> !hi_flag_w[g])
            else $error("unlatched high flag outlives its condition");

         disabled_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
            SAMPLE_VALID_IN && !ch_en_r[g] ##1 !ch_en_r[g]
            |-> flags_w[g*FLG_STRIDE +: FLG_STRIDE] == '0 && !err_w[g])
            else $error("status flags shown for disabled channel");

         pass_through_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
            SAMPLE_VALID_IN && ch_en_r[g] && !alm_en_r[g] && !OPEN_WIRE_IN[g] &&
            $signed(SAMPLE_DATA_IN[g*DW +: DW]) <= $signed(NORM_MAX_DEF) &&
            $signed(SAMPLE_DATA_IN[g*DW +: DW]) >= $signed(NORM_MIN_DEF)
            |=> value_w[g] == $past(SAMPLE_DATA_IN[g*DW +: DW]) && !above_w[g] && !below_w[g])
            else $error("in-range sample not passed unchanged");

         err_or_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
            err_w[g] == |flags_w[g*FLG_STRIDE +: FLG_STRIDE])
            else $error("error summary differs from flag OR");
      end
   endgenerate

   // Read mux; everything unmapped reads zero
   wire [DW-1:0] err_word_w = {{(DW-NCH){1'b0}}, err_w};
   wire [DW-1:0] rel_word_w = {{(DW-REL_W){1'b0}}, release_r};
   wire [DW-1:0] en_word_w  = {{(DW-NCH){1'b0}}, ch_en_r};
   wire [DW-1:0] alm_word_w = {{(DW-NCH){1'b0}}, alm_en_r};
   wire [DW-1:0] lat_word_w = {{(DW-NCH){1'b0}}, lat_en_r};
   wire [DW-1:0] cfg1_w     = {stamp_en_r, {(DW-1){1'b0}}};
   wire [DW-1:0] rd_mux_w   =
      rd_value_w                    ? value_w[idx_w]  :
      (ADDR_IN == ADDR_STAMP)       ? stamp_w         :
      (ADDR_IN == ADDR_ERR)         ? err_word_w      :
      (ADDR_IN == ADDR_FLAGS)       ? flags_w         :
      (ADDR_IN == ADDR_RELEASE_RB)  ? rel_word_w      :
      (ADDR_IN == ADDR_CFG1)        ? cfg1_w          :
      (ADDR_IN == ADDR_CH_EN)       ? en_word_w       :
      (ADDR_IN == ADDR_ALM_EN)      ? alm_word_w      :
      (ADDR_IN == ADDR_LATCH_EN)    ? lat_word_w      :
      rd_hi_w                       ? hi_thr_r[idx_w] :
      rd_lo_w                       ? lo_thr_r[idx_w] :
      WORD_ZERO;

   // Data stand only in the cycle after the strobe
   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         rdata_r <= WORD_ZERO;
      end else begin
         rdata_r <= RD_IN ? rd_mux_w : WORD_ZERO;
      end
   end

   assign RDATA_OUT = rdata_r;

   rd_flags_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      RD_IN && ADDR_IN == ADDR_FLAGS |=> RDATA_OUT == $past(flags_w))
      else $error("flag word read back wrong");

   err_spare_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      RD_IN && ADDR_IN == ADDR_ERR |=> RDATA_OUT[DW-1:NCH] == '0 &&
      RDATA_OUT[NCH-1:0] == $past(err_w))
      else $error("error word spare bits not zero");

   stamp_msb_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      RD_IN && ADDR_IN == ADDR_STAMP |=> !RDATA_OUT[SIGN_POS])
      else $error("timestamp spare bit set");

   rd_idle_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      !RD_IN |=> RDATA_OUT == WORD_ZERO)
      else $error("read data outside its cycle");

   rel_store_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      wr_rel_w |=> release_r == $past(WDATA_IN[REL_W-1:0]))
      else $error("release bits not stored");
endmodule
`default_nettype wire

// [test/aisi_ctrl_model.sv]
// Controller model: masters the register bus of the status image block.
// Assumes the bench calls wr and rd from one process, one at a time.
`timescale 1ns/1ps
`default_nettype none
module aisi_ctrl_model (
   input  wire logic        clk_in,
   input  wire logic [15:0] rdata_in,
   output logic      [4:0]  addr_out,
   output logic      [15:0] wdata_out,
   output logic             wr_out,
   output logic             rd_out
);
   import aisi_pkg::*;
   initial begin
      addr_out  = 5'h00;
      wdata_out = 16'h0000;
      wr_out    = 1'b0;
      rd_out    = 1'b0;
   end
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_in);
      addr_out  <= a;
      wdata_out <= (a == ADDR_RELEASE) ? (d & 16'h00FF) : d;
      wr_out    <= 1'b1;
      @(posedge clk_in);
      wr_out    <= 1'b0;
      // Stale data must not look valid after the strobe
      wdata_out <= ~wdata_out;
   endtask
   task automatic rd(input logic [4:0] a, output logic [15:0] q);
      @(posedge clk_in);
      addr_out <= a;
      rd_out   <= 1'b1;
      @(posedge clk_in);
      rd_out   <= 1'b0;
      #1 q = rdata_in;
   endtask
endmodule
`default_nettype wire

// [test/testbench.sv]
// Self-checking bench for the analog input status image.
// Assumes a 40 MHz clock and a shortened millisecond count of 4 cycles.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import aisi_pkg::*;
   logic        clk, rst, sv, wr, rd;
   logic [63:0] sd;
   logic [3:0]  ow;
   logic [4:0]  addr;
   logic [15:0] wdata, rdata, q, s1;
   int          n_mismatch, compares, cyc;
   aisi_top #(.MS_CYCLES(4)) aisi_top_i (.REF_CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
      .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .SAMPLE_VALID_IN(sv), .SAMPLE_DATA_IN(sd), .OPEN_WIRE_IN(ow));
   aisi_ctrl_model aisi_ctrl_model_i (.clk_in(clk), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
      .wr_out(wr), .rd_out(rd));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rc(input logic [4:0] a, input logic [15:0] exp);
      aisi_ctrl_model_i.rd(a, q);
      chk(q, exp);
   endtask
   task automatic wrr(input logic [4:0] a, input logic [15:0] d);
      aisi_ctrl_model_i.wr(a, d);
   endtask
   task automatic smp(input logic [63:0] d, input logic [3:0] o);
      @(posedge clk);
      sv <= 1'b1;
      sd <= d;
      ow <= o;
      @(posedge clk);
      sv <= 1'b0;
      sd <= ~d;
   endtask
   // Whole sequence needs well under a thousand cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         summarize();
      end
   end
   initial begin
      rst = 1'b1;
      sv = 1'b0;
      sd = 64'h0;
      ow = 4'h0;
      n_mismatch = 0;
      compares = 0;
      cyc = 0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rc(ADDR_CH_EN, 16'h0000);
      rc(ADDR_FLAGS, 16'h0000);
      rc(5'h07, 16'h0000);
      wrr(ADDR_CH_EN, 16'h000F);
      smp({16'h0010, 16'h8200, 16'h7E00, 16'hF123}, 4'h8);
      rc(5'h00, 16'hF123);
      rc(5'h01, 16'h7FFF);
      rc(5'h02, 16'h8000);
      rc(5'h03, 16'h8000);
      rc(ADDR_FLAGS, 16'h2210);
      rc(ADDR_ERR, 16'h000E);
      smp(64'h0, 4'h0);
      rc(ADDR_FLAGS, 16'h0000);
      rc(ADDR_ERR, 16'h0000);
      for (int n = 0; n < 4; n++) begin
         wrr(ADDR_HI_BASE + 5'(n), 16'h1000);
         wrr(ADDR_LO_BASE + 5'(n), 16'hF000);
      end
      rc(ADDR_HI_BASE + 5'h02, 16'h1000);
      rc(ADDR_LO_BASE + 5'h03, 16'hF000);
      wrr(ADDR_ALM_EN, 16'h000F);
      smp({32'h0, 16'hE000, 16'h2000}, 4'h0);
      rc(5'h00, 16'h7FFF);
      rc(5'h01, 16'h8000);
      rc(ADDR_FLAGS, 16'h0084);
      rc(ADDR_ERR, 16'h0003);
      smp(64'h0, 4'h0);
      rc(ADDR_FLAGS, 16'h0000);
      wrr(ADDR_LATCH_EN, 16'h000F);
      smp(64'h2000, 4'h0);
      smp(64'h0, 4'h0);
      rc(ADDR_FLAGS, 16'h0004);
      rc(ADDR_ERR, 16'h0001);
      smp(64'h2000, 4'h0);
      wrr(ADDR_RELEASE, 16'hFF01);
      rc(ADDR_RELEASE_RB, 16'h0001);
      rc(ADDR_FLAGS, 16'h0004);
      smp(64'h0, 4'h0);
      rc(ADDR_FLAGS, 16'h0000);
      smp(64'h2000, 4'h0);
      smp(64'h0, 4'h0);
      rc(ADDR_FLAGS, 16'h0000);
      wrr(ADDR_RELEASE, 16'h0000);
      smp(64'hE000_0000, 4'h0);
      smp(64'h0, 4'h0);
      rc(ADDR_FLAGS, 16'h0080);
      smp(64'hE000_0000, 4'h0);
      wrr(ADDR_RELEASE, 16'h0008);
      rc(ADDR_FLAGS, 16'h0080);
      smp(64'h0, 4'h0);
      rc(ADDR_FLAGS, 16'h0000);
      wrr(ADDR_RELEASE, 16'h0000);
      wrr(ADDR_CH_EN, 16'h000E);
      smp(64'h2000, 4'h0);
      rc(ADDR_FLAGS, 16'h0000);
      rc(5'h00, 16'h0000);
      wrr(ADDR_CFG1, 16'h8000);
      smp(64'h0, 4'h0);
      aisi_ctrl_model_i.rd(ADDR_STAMP, s1);
      // Next strobe lands exactly 40 cycles, ten stamp ticks, later
      repeat (36) @(posedge clk);
      smp(64'h0, 4'h0);
      rc(ADDR_STAMP, (s1 + 16'h000A) & 16'h7FFF);
      chk(s1 & 16'h8000, 16'h0000);
      wrr(ADDR_CFG1, 16'h0000);
      smp(64'h0, 4'h0);
      rc(ADDR_STAMP, 16'h0000);
      summarize();
   end
endmodule
`default_nettype wire
